// file: core/ssc_ctrl.sv
// How it works
// - Start request never cleared by hardware
// - Stop request as master sends STOP
// - Stop request cleared when STOP detected
// - Stop in bus error recovers silently
// - Start plus stop as master: STOP, START
// - Event set on every status except idle
// - Only software clears the event flag
// - SCL held low while event set, except after bus error or lost arbitration
// - Clearing event resumes per control flags
// - Start waits for free bus, then START
// - Start as active master: repeated START
// - Receiver acknowledge follows ack flag
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
module ssc_ctrl
   import ssc_pkg::*;
#(
   parameter int PHASE_LEN = ssc_pkg::PHASE_CLKS
) (
   // System clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register port
   input wire logic [ssc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ssc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ssc_pkg::DATA_W-1:0] reg_rdata,
   // Two-wire bus, open drain
   input wire logic link_clk,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oen,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oen
);
   import ssc_pkg::*;

   // ---------------- System clock side ----------------
   logic start_r;
   logic stop_r;
   logic event_r;
   logic ack_r;
   logic [7:0] data_r;
   logic [7:0] status_r;
   logic [7:0] rdata_r;
   logic cmd_pend_r;
   logic ctrl_wr;
   logic event_clr;
   logic idle_start;
   logic rpt_in;
   logic [RPT_W-1:0] rpt_word;
   logic rpt_clr_stop;
   logic [7:0] rpt_code;

   ssc_xfer_if #(.W(CMD_W)) cmd_x ();
   ssc_xfer_if #(.W(RPT_W)) rpt_x ();

   ssc_xfer #(.W(CMD_W)) u_cmd (
      .clk_src(mclk),
      .clk_dst(link_clk),
      .resetn(resetn),
      .x(cmd_x)
   );

   ssc_xfer #(.W(RPT_W)) u_rpt (
      .clk_src(link_clk),
      .clk_dst(mclk),
      .resetn(resetn),
      .x(rpt_x)
   );

   assign ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
   assign rpt_in = rpt_x.valid;
   assign rpt_word = rpt_x.dst_data;
   assign rpt_clr_stop = rpt_word[RPT_W-1];
   assign rpt_code = rpt_word[15:8];
   assign event_clr = ctrl_wr && event_r && !reg_wdata[BIT_EVENT];
   assign idle_start = ctrl_wr && !event_r && reg_wdata[BIT_START] && !start_r
                       && (status_r == ST_IDLE);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         start_r <= 1'b0;
      end else if (ctrl_wr) begin
         start_r <= reg_wdata[BIT_START];
      end
   end

   // A software set in the same cycle as a detected STOP keeps the request
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stop_r <= 1'b0;
      end else if (ctrl_wr && reg_wdata[BIT_STOP]) begin
         stop_r <= 1'b1;
      end else if (rpt_in && rpt_clr_stop) begin
         stop_r <= 1'b0;
      end else if (ctrl_wr) begin
         stop_r <= 1'b0;
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         event_r <= 1'b0;
      end else if (rpt_in && rpt_code != ST_IDLE) begin
         event_r <= 1'b1;
      end else if (event_clr) begin
         event_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_r <= 1'b0;
      end else if (ctrl_wr) begin
         ack_r <= reg_wdata[BIT_ACK];
      end
   end

   // Status changes only on a report, and reports follow a command
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         status_r <= ST_IDLE;
      end else if (rpt_in) begin
         status_r <= rpt_code;
      end
   end

   // Received bytes land in the shared data register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         data_r <= '0;
      end else if (rpt_in && (rpt_code == ST_RX_ACK || rpt_code == ST_RX_NACK)) begin
         data_r <= rpt_word[7:0];
      end else if (reg_wr && reg_addr == REG_DATA) begin
         data_r <= reg_wdata;
      end
   end

   // Command is captured after the clearing write, so settings made with it count
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmd_pend_r <= 1'b0;
      end else if (event_clr || idle_start) begin
         cmd_pend_r <= 1'b1;
      end else if (!cmd_x.busy) begin
         cmd_pend_r <= 1'b0;
      end
   end

   assign cmd_x.send = cmd_pend_r && !event_clr && !idle_start;
   assign cmd_x.src_data = {start_r, stop_r, ack_r, data_r};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: rdata_r <= 8'({start_r, stop_r, event_r, ack_r}) << BIT_ACK;
            REG_STATUS: rdata_r <= status_r;
            REG_DATA: rdata_r <= data_r;
            default: rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   assign reg_rdata = rdata_r;

   // ---------------- Link clock side ----------------
   logic scl_q1_r, scl_q2_r, scl_d_r;
   logic sda_q1_r, sda_q2_r, sda_d_r;
   logic start_det, stop_det;
   logic bus_busy_r;
   logic stop_seen_r;
   ssc_eng_t st_r;
   logic [DIV_W-1:0] div_r;
   logic [1:0] ph_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic master_r, rd_r, addr_r, then_start_r, c_ack_r;
   logic scl_pull_r, sda_pull_r;
   logic [7:0] code_l_r;
   logic rpt_pend_r;
   logic [RPT_W-1:0] rpt_out_r;
   logic tick, adv;
   logic sending;
   logic c_start, c_stop, c_ack;
   logic [7:0] c_data;

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         scl_q1_r <= 1'b1;
         scl_q2_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_q1_r <= 1'b1;
         sda_q2_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_q1_r <= scl_i;
         scl_q2_r <= scl_q1_r;
         scl_d_r <= scl_q2_r;
         sda_q1_r <= sda_i;
         sda_q2_r <= sda_q1_r;
         sda_d_r <= sda_q2_r;
      end
   end

   assign start_det = scl_q2_r && scl_d_r && sda_d_r && !sda_q2_r;
   assign stop_det = scl_q2_r && scl_d_r && !sda_d_r && sda_q2_r;

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         bus_busy_r <= 1'b0;
      end else if (start_det) begin
         bus_busy_r <= 1'b1;
      end else if (stop_det) begin
         bus_busy_r <= 1'b0;
      end
   end

   // A STOP seen before the report goes out is still passed on
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         stop_seen_r <= 1'b0;
      end else if (stop_det) begin
         stop_seen_r <= 1'b1;
      end else if (rpt_x.send && !rpt_x.busy) begin
         stop_seen_r <= 1'b0;
      end
   end

   assign {c_start, c_stop, c_ack, c_data} = cmd_x.dst_data;
   assign tick = (div_r == DIV_W'(PHASE_LEN - 1));
   // After SCL is released, wait while another device still holds it low
   assign adv = tick && !(ph_r == 2'h2 && !scl_q2_r && !scl_pull_r);
   assign sending = addr_r || !rd_r;
   assign rpt_x.send = rpt_pend_r;
   assign rpt_x.src_data = rpt_out_r;

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         div_r <= '0;
      end else if (tick || st_r == E_IDLE || st_r == E_HOLD) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         rpt_pend_r <= 1'b0;
         rpt_out_r <= '0;
         code_l_r <= ST_IDLE;
      end else if (tick && st_r == E_BIT && ph_r == PH_LAST && bit_r == ACK_BIT) begin
         rpt_pend_r <= 1'b1;
         code_l_r <= addr_r ? (sh_r[0] ? (sda_q2_r ? ST_AR_NACK : ST_AR_ACK)
                                      : (sda_q2_r ? ST_AW_NACK : ST_AW_ACK))
                    : rd_r ? (c_ack_r ? ST_RX_ACK : ST_RX_NACK)
                    : (sda_q2_r ? ST_TX_NACK : ST_TX_ACK);
         rpt_out_r <= {stop_seen_r, (addr_r ? (sh_r[0] ? (sda_q2_r ? ST_AR_NACK : ST_AR_ACK)
                                      : (sda_q2_r ? ST_AW_NACK : ST_AW_ACK))
                    : rd_r ? (c_ack_r ? ST_RX_ACK : ST_RX_NACK)
                    : (sda_q2_r ? ST_TX_NACK : ST_TX_ACK)), sh_r};
      end else if (tick && st_r == E_START && ph_r == PH_LAST) begin
         rpt_pend_r <= 1'b1;
         code_l_r <= master_r ? ST_RSTART : ST_START;
         rpt_out_r <= {stop_seen_r, (master_r ? ST_RSTART : ST_START), sh_r};
      end else if (tick && st_r == E_STOP && ph_r == PH_LAST && !then_start_r) begin
         rpt_pend_r <= 1'b1;
         code_l_r <= ST_IDLE;
         rpt_out_r <= {1'b1, ST_IDLE, sh_r};
      end else if (st_r == E_BIT && (start_det || stop_det)) begin
         rpt_pend_r <= 1'b1;
         code_l_r <= ST_BUS_ERR;
         rpt_out_r <= {stop_det, ST_BUS_ERR, sh_r};
      end else if (adv && st_r == E_BIT && ph_r == 2'h2 && bit_r != ACK_BIT && sending
                   && sh_r[7] && !sda_q2_r) begin
         rpt_pend_r <= 1'b1;
         code_l_r <= ST_ARB_LOST;
         rpt_out_r <= {stop_seen_r, ST_ARB_LOST, sh_r};
      end else if (cmd_x.valid && code_l_r == ST_BUS_ERR && c_stop) begin
         rpt_pend_r <= 1'b1;
         code_l_r <= ST_IDLE;
         rpt_out_r <= {1'b1, ST_IDLE, sh_r};
      end else if (!rpt_x.busy) begin
         rpt_pend_r <= 1'b0;
      end
   end

   // Bit engine: four phases per SCL period, SDA moves only while SCL is low, except that START and STOP move it while SCL is high
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= E_IDLE;
         ph_r <= '0;
         bit_r <= '0;
         sh_r <= '0;
         master_r <= 1'b0;
         rd_r <= 1'b0;
         addr_r <= 1'b0;
         then_start_r <= 1'b0;
         c_ack_r <= 1'b0;
         scl_pull_r <= 1'b0;
         sda_pull_r <= 1'b0;
      end else begin
         case (st_r)
            E_IDLE, E_HOLD: begin
               ph_r <= '0;
               if (cmd_x.valid) begin
                  c_ack_r <= c_ack;
                  if (code_l_r == ST_BUS_ERR && c_stop) begin
                     master_r <= 1'b0;
                     scl_pull_r <= 1'b0;
                     sda_pull_r <= 1'b0;
                     st_r <= E_IDLE;
                  end else if (master_r && c_stop) begin
                     then_start_r <= c_start;
                     st_r <= E_STOP;
                  end else if (c_start) begin
                     st_r <= (master_r || !bus_busy_r) ? E_START : E_WAITF;
                  end else if (master_r) begin
                     sh_r <= (rd_r && !addr_r) ? 8'hff : c_data;
                     bit_r <= '0;
                     st_r <= E_BIT;
                  end else begin
                     scl_pull_r <= 1'b0;
                     st_r <= E_IDLE;
                  end
               end
            end
            E_WAITF: begin
               if (!bus_busy_r) begin
                  st_r <= E_START;
               end
            end
            E_START: begin
               if (adv) begin
                  ph_r <= ph_r + 1'b1;
                  case (ph_r)
                     2'h0: sda_pull_r <= 1'b0;
                     2'h1: scl_pull_r <= 1'b0;
                     2'h2: sda_pull_r <= 1'b1;
                     default: begin
                        scl_pull_r <= 1'b1;
                        master_r <= 1'b1;
                        addr_r <= 1'b1;
                        st_r <= E_HOLD;
                     end
                  endcase
               end
            end
            E_BIT: begin
               if (start_det || stop_det) begin
                  master_r <= 1'b0;
                  scl_pull_r <= 1'b0;
                  sda_pull_r <= 1'b0;
                  st_r <= E_IDLE;
               end else if (adv) begin
                  ph_r <= ph_r + 1'b1;
                  case (ph_r)
                     2'h0: begin
                        scl_pull_r <= 1'b1;
                        if (bit_r == ACK_BIT) begin
                           sda_pull_r <= sending ? 1'b0 : c_ack_r;
                        end else begin
                           sda_pull_r <= sending && !sh_r[7];
                        end
                     end
                     2'h1: scl_pull_r <= 1'b0;
                     2'h2: begin
                        if (bit_r != ACK_BIT) begin
                           sh_r <= {sh_r[6:0], sda_q2_r};
                           if (sending && sh_r[7] && !sda_q2_r) begin
                              master_r <= 1'b0;
                              sda_pull_r <= 1'b0;
                              st_r <= E_IDLE;
                           end
                        end
                     end
                     default: begin
                        scl_pull_r <= 1'b1;
                        if (bit_r == ACK_BIT) begin
                           if (addr_r) begin
                              rd_r <= sh_r[0];
                           end
                           addr_r <= 1'b0;
                           sda_pull_r <= 1'b0;
                           st_r <= E_HOLD;
                        end else begin
                           bit_r <= bit_r + 1'b1;
                        end
                     end
                  endcase
               end
            end
            E_STOP: begin
               if (adv) begin
                  ph_r <= ph_r + 1'b1;
                  case (ph_r)
                     2'h0: sda_pull_r <= 1'b1;
                     2'h1: scl_pull_r <= 1'b0;
                     2'h2: sda_pull_r <= 1'b0;
                     default: begin
                        master_r <= 1'b0;
                        st_r <= then_start_r ? E_START : E_IDLE;
                     end
                  endcase
               end
            end
            default: st_r <= E_IDLE;
         endcase
      end
   end

   // Open-drain pins: the data level is always low, the enable does the work
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oen <= 1'b1;
         sda_oen <= 1'b1;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oen <= ~scl_pull_r;
         sda_oen <= ~sda_pull_r;
      end
   end
endmodule // ssc_ctrl

// file: pkg/ssc_pkg.sv
package ssc_pkg;
   // Register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
   localparam logic [ADDR_W-1:0] REG_DATA = 4'h2;
   // Control register fields
   localparam int BIT_START = 5;
   localparam int BIT_STOP = 4;
   localparam int BIT_EVENT = 3;
   localparam int BIT_ACK = 2;
   // Status codes
   localparam logic [7:0] ST_BUS_ERR = 8'h00;
   localparam logic [7:0] ST_START = 8'h08;
   localparam logic [7:0] ST_RSTART = 8'h10;
   localparam logic [7:0] ST_AW_ACK = 8'h18;
   localparam logic [7:0] ST_AW_NACK = 8'h20;
   localparam logic [7:0] ST_TX_ACK = 8'h28;
   localparam logic [7:0] ST_TX_NACK = 8'h30;
   localparam logic [7:0] ST_ARB_LOST = 8'h38;
   localparam logic [7:0] ST_AR_ACK = 8'h40;
   localparam logic [7:0] ST_AR_NACK = 8'h48;
   localparam logic [7:0] ST_RX_ACK = 8'h50;
   localparam logic [7:0] ST_RX_NACK = 8'h58;
   localparam logic [7:0] ST_IDLE = 8'hf8;
   // Bit timing on the link clock
   localparam int SCL_PERIOD_NS = 10000;
   localparam int LINK_PERIOD_NS = 12;
   localparam int PHASES = 4;
   localparam int PHASE_CLKS = SCL_PERIOD_NS / (PHASES * LINK_PERIOD_NS);
   localparam int DIV_W = 16;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [1:0] PH_LAST = 2'h3;
   // Crossing word widths
   localparam int CMD_W = 11;
   localparam int RPT_W = 17;
   // Link engine states
   typedef enum logic [5:0] {
      E_IDLE = 6'b000001,
      E_WAITF = 6'b000010,
      E_START = 6'b000100,
      E_BIT = 6'b001000,
      E_STOP = 6'b010000,
      E_HOLD = 6'b100000
   } ssc_eng_t;
endpackage

// file: pkg/ssc_xfer_if.sv
`timescale 1ns/1ns
interface ssc_xfer_if #(parameter int W = 8);
   logic send;
   logic [W-1:0] src_data;
   logic busy;
   logic valid;
   logic [W-1:0] dst_data;
   modport xfer (input send, input src_data, output busy, output valid, output dst_data);
   modport user (output send, output src_data, input busy, input valid, input dst_data);
endinterface // ssc_xfer_if

// file: core/ssc_xfer.sv
`timescale 1ns/1ns
// Toggle handshake carrying one word from the source clock to the destination clock
module ssc_xfer #(
   parameter int W = 8
) (
   // Clocks and reset
   input wire logic clk_src,
   input wire logic clk_dst,
   input wire logic resetn,
   // Word channel
   ssc_xfer_if.xfer x
);
   logic req_r;
   logic [W-1:0] hold_r;
   logic ack_s1_r;
   logic ack_s2_r;
   logic req_s1_r;
   logic req_s2_r;
   logic req_s3_r;
   logic valid_r;
   logic [W-1:0] out_r;

   assign x.busy = req_r ^ ack_s2_r;
   assign x.valid = valid_r;
   assign x.dst_data = out_r;

   // Word is held until the far side has acknowledged, so it is stable when sampled
   always_ff @(posedge clk_src or negedge resetn) begin
      if (!resetn) begin
         req_r <= 1'b0;
         hold_r <= '0;
      end else if (x.send && !x.busy) begin
         req_r <= ~req_r;
         hold_r <= x.src_data;
      end
   end

   always_ff @(posedge clk_src or negedge resetn) begin
      if (!resetn) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         ack_s1_r <= req_s3_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   always_ff @(posedge clk_dst or negedge resetn) begin
      if (!resetn) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
         valid_r <= 1'b0;
         out_r <= '0;
      end else begin
         req_s1_r <= req_r;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
         valid_r <= req_s2_r ^ req_s3_r;
         if (req_s2_r ^ req_s3_r) begin
            out_r <= hold_r;
         end
      end
   end
endmodule // ssc_xfer

// file: test/ssc_ctrl_asserts.sv
`timescale 1ns/1ns
module ssc_ctrl_asserts
   import ssc_pkg::*;
#(
   parameter int PHASE_LEN = 4
) (
   // Clocks and reset
   input wire logic mclk,
   input wire logic resetn,
   input wire logic link_clk,
   // Register port
   input wire logic [ssc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ssc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ssc_pkg::DATA_W-1:0] reg_rdata,
   // Bus wires
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oen,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oen
);
   // What earlier reads proved; any control write makes it stale
   logic wr_c, rc_d, rs_d, evt_k, idle_k, st_v, go_sh, ack_sh;
   logic [7:0] st_k;
   assign wr_c = reg_wr && reg_addr == REG_CTRL;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rc_d <= 1'b0;
         rs_d <= 1'b0;
      end else begin
         rc_d <= reg_rd && reg_addr == REG_CTRL;
         rs_d <= reg_rd && reg_addr == REG_STATUS;
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         go_sh <= 1'b0;
         ack_sh <= 1'b0;
      end else if (wr_c) begin
         go_sh <= reg_wdata[BIT_START];
         ack_sh <= reg_wdata[BIT_ACK];
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) evt_k <= 1'b0;
      else if (wr_c) evt_k <= 1'b0;
      else if (rc_d && reg_rdata[BIT_EVENT]) evt_k <= 1'b1;
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_v <= 1'b0;
         st_k <= 8'h00;
         idle_k <= 1'b0;
      end else if (wr_c) begin
         st_v <= 1'b0;
         idle_k <= 1'b0;
      end else if (rs_d) begin
         idle_k <= reg_rdata == ST_IDLE;
         if (evt_k && !st_v) begin
            st_v <= 1'b1;
            st_k <= reg_rdata;
         end
      end
   end
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_unmapped_zero: assert property (reg_rd && reg_addr > REG_DATA |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_flags_sticky: assert property (reg_rd && reg_addr == REG_CTRL |=>
      reg_rdata[BIT_START] == $past(go_sh) && reg_rdata[BIT_ACK] == $past(ack_sh))
      else $error("start or ack flag changed without a write");
   a_event_held: assert property (reg_rd && reg_addr == REG_CTRL && evt_k |=> reg_rdata[BIT_EVENT])
      else $error("event flag dropped without a write");
   a_status_stable: assert property (reg_rd && reg_addr == REG_STATUS && st_v |=> reg_rdata == st_k)
      else $error("status moved while event set");
   a_scl_stretched: assert property (evt_k |-> !scl_oen)
      else $error("clock released while event set");
   a_idle_no_event: assert property (reg_rd && reg_addr == REG_CTRL && idle_k |=> !reg_rdata[BIT_EVENT])
      else $error("event set in idle status");
   a_pins_open_drain: assert property (@(posedge link_clk) disable iff (!resetn) !scl_o && !sda_o)
      else $error("pin driven high");
   c_event: cover property (rc_d && reg_rdata[BIT_EVENT] && reg_rdata[BIT_START]);
   c_rx_nack: cover property (rs_d && reg_rdata == ST_RX_NACK);
   c_stop_start: cover property (wr_c && reg_wdata[BIT_START] && reg_wdata[BIT_STOP]);
endmodule // ssc_ctrl_asserts

// file: test/ssc_slave_model.sv
`timescale 1ns/1ns
// Target on the wires; it only pulls low, the pull-ups supply the high level
module ssc_slave_model #(
   parameter logic [6:0] DEV_ADDR = 7'h52
) (
   // Wire levels and pull-downs
   input wire logic scl,
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull,
   // Control and observation
   input wire logic [7:0] tx_byte,
   input wire logic slow,
   output logic [7:0] rx_byte,
   output logic mack,
   output int n_start,
   output int n_stop
);
   logic [7:0] sh = 8'h00;
   logic first = 1'b0, sel = 1'b0, rd = 1'b0;
   int cnt = 0;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      rx_byte = 8'h00;
      mack = 1'b1;
      n_start = 0;
      n_stop = 0;
   end
   always @(negedge sda) if (scl) begin
      n_start++;
      cnt = 0;
      first = 1'b1;
      sel = 1'b0;
   end
   always @(posedge sda) if (scl) begin
      n_stop++;
      cnt = 0;
      sel = 1'b0;
   end
   always @(posedge scl) begin
      cnt++;
      if (cnt <= 8) sh = {sh[6:0], sda};
      else if (sel && rd && !first) begin
         mack = sda;
         // A refused byte ends our turn so the master can stop
         if (sda) sel = 1'b0;
      end
   end
   always @(negedge scl) begin
      if (cnt == 8) begin
         if (first) begin
            sel = sh[7:1] == DEV_ADDR;
            rd = sh[0];
         end else if (sel && !rd) rx_byte = sh;
         sda_pull = sel && (first || !rd);
      end else if (cnt == 9) begin
         cnt = 0;
         first = 1'b0;
         sda_pull = sel && rd && !tx_byte[7];
         if (slow) begin
            scl_pull = 1'b1;
            #700 scl_pull = 1'b0;
         end
      end else sda_pull = sel && rd && !first && !tx_byte[7-cnt];
   end
endmodule // ssc_slave_model

// file: test/ssc_ctrl_bench.sv
`timescale 1ns/1ns
module ssc_ctrl_bench;
   import ssc_pkg::*;
   localparam logic [7:0] F_GO = 8'h01 << BIT_START;
   localparam logic [7:0] F_END = 8'h01 << BIT_STOP;
   localparam logic [7:0] F_EV = 8'h01 << BIT_EVENT;
   localparam logic [7:0] F_ACK = 8'h01 << BIT_ACK;
   localparam logic [6:0] DEV = 7'h52;
   logic mclk = 1'b0, link_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
   logic scl_o, scl_oen, sda_o, sda_oen, scl_pull, sda_pull, mack, rd_d = 1'b0, slow = 1'b0;
   logic [7:0] tx_byte = 8'h00, rx_byte, d, sent;
   logic [31:0] seed = 32'hc33f;
   logic [8:0] notes[$];
   int n_start, n_stop, s0, p0, failures = 0, checks_done = 0;
   wire logic scl = (scl_oen || scl_o) && !scl_pull;
   wire logic sda = (sda_oen || sda_o) && !sda_pull;
   always #5 mclk = ~mclk;
   always #6 link_clk = ~link_clk;
   ssc_ctrl #(.PHASE_LEN(4)) u_ssc_ctrl (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o), .scl_oen(scl_oen), .sda_i(sda),
      .sda_o(sda_o), .sda_oen(sda_oen));
   ssc_slave_model #(.DEV_ADDR(DEV)) u_ssc_slave_model (.scl(scl), .sda(sda),
      .scl_pull(scl_pull), .sda_pull(sda_pull), .tx_byte(tx_byte), .slow(slow),
      .rx_byte(rx_byte), .mack(mack), .n_start(n_start), .n_stop(n_stop));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic complete_run;
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   // Polls queue a note without the check bit so the watcher stays in step
   task automatic rd(input logic [3:0] a, input logic chk, input logic [7:0] exp);
      notes.push_back({chk, exp});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata;
   endtask
   task automatic wait_st(input logic [7:0] code);
      int i = 0;
      do begin
         rd(REG_STATUS, 1'b0, 8'h00);
         i++;
      end while (d !== code && i < 600);
      cmp(d, code);
   endtask
   // Software prepares data first, then sets the flags and clears the event in one write
   task automatic step(input logic [7:0] c, input logic [7:0] code, input logic [7:0] exp);
      wr(REG_CTRL, c);
      wait_st(code);
      rd(REG_CTRL, 1'b1, exp);
   endtask
   always @(posedge mclk) begin
      if (rd_d && notes.size() > 0) begin
         if (notes[0][8]) cmp(reg_rdata, notes[0][7:0]);
         void'(notes.pop_front());
      end
      rd_d <= reg_rd;
   end
   // About 13 us of traffic expected; allow ample margin
   initial begin
      #400000;
      failures++;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rd(REG_CTRL, 1'b1, 8'h00);
      rd(REG_STATUS, 1'b1, ST_IDLE);
      wr(4'h9, 8'hff);
      rd(4'h9, 1'b1, 8'h00);
      wr(REG_CTRL, F_EV);
      rd(REG_CTRL, 1'b1, 8'h00);
      wr(REG_DATA, {DEV, 1'b0});
      step(F_GO | F_ACK, ST_START, F_GO | F_EV | F_ACK);
      repeat (40) @(posedge mclk);
      cmp({7'h00, scl}, 8'h00);
      rd(REG_STATUS, 1'b1, ST_START);
      step(F_ACK, ST_AW_ACK, F_EV | F_ACK);
      seed = lfsr(seed);
      sent = seed[15:8];
      tx_byte <= seed[7:0];
      slow <= 1'b1;
      wr(REG_DATA, sent);
      step(F_ACK, ST_TX_ACK, F_EV | F_ACK);
      cmp(rx_byte, sent);
      step(F_GO | F_ACK, ST_RSTART, F_GO | F_EV | F_ACK);
      wr(REG_DATA, {DEV, 1'b1});
      step(F_ACK, ST_AR_ACK, F_EV | F_ACK);
      step(F_ACK, ST_RX_ACK, F_EV | F_ACK);
      cmp({7'h00, mack}, 8'h00);
      rd(REG_DATA, 1'b1, tx_byte);
      step(8'h00, ST_RX_NACK, F_EV);
      cmp({7'h00, mack}, 8'h01);
      s0 = n_start;
      p0 = n_stop;
      step(F_GO | F_END, ST_START, F_GO | F_EV);
      cmp(8'(n_stop - p0), 8'h01);
      cmp(8'(n_start - s0), 8'h01);
      p0 = n_stop;
      wr(REG_CTRL, F_END);
      wait_st(ST_IDLE);
      repeat (20) @(posedge mclk);
      rd(REG_CTRL, 1'b1, 8'h00);
      cmp(8'(n_stop - p0), 8'h01);
      repeat (4) @(posedge mclk);
      complete_run;
   end
endmodule // ssc_ctrl_bench
bind ssc_ctrl ssc_ctrl_asserts #(.PHASE_LEN(PHASE_LEN)) u_ssc_ctrl_asserts (.mclk(mclk),
   .resetn(resetn), .link_clk(link_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oen(scl_oen), .sda_i(sda_i), .sda_o(sda_o), .sda_oen(sda_oen));
